//--- verilog/status_flags_pkg.sv
// Package for the processor status flags register block.
// Assumes 32-bit AXI4-Lite, 16-bit status word.
package status_flags_pkg;
   // -----------------------------------------------
   // Register map (byte addresses)
   // -----------------------------------------------
   localparam logic [7:0] STATUS_OFFSET    = 8'h00;
   localparam logic [7:0] CONTROL_OFFSET   = 8'h04;
   localparam logic [7:0] PRIORITY_OFFSET  = 8'h08;
   localparam logic [7:0] IRQ_STAT_OFFSET  = 8'h0C;
   localparam logic [7:0] IRQ_MASK_OFFSET  = 8'h10;
   // -----------------------------------------------
   // Status word field positions
   // -----------------------------------------------
   localparam int BIT_ACC_A_OVF   = 15;
   localparam int BIT_ACC_B_OVF   = 14;
   localparam int BIT_ACC_A_SAT   = 13;
   localparam int BIT_ACC_B_SAT   = 12;
   localparam int BIT_ANY_OVF     = 11;
   localparam int BIT_ANY_SAT     = 10;
   localparam int BIT_LOOP_ACTIVE = 9;
   localparam int BIT_HALF_CARRY  = 8;
   localparam int BIT_PRIO_HI     = 7;
   localparam int BIT_PRIO_LO     = 5;
   localparam int BIT_REPEAT      = 4;
   localparam int BIT_NEGATIVE    = 3;
   localparam int BIT_OVERFLOW    = 2;
   localparam int BIT_ZERO        = 1;
   localparam int BIT_CARRY       = 0;
   // Control register: core priority bit 3, nesting disable bit 15
   localparam int BIT_CORE_PRIO3  = 3;
   localparam int BIT_NEST_DIS    = 15;
   // -----------------------------------------------
   // Reset values and response codes
   // -----------------------------------------------
   localparam logic [15:0] STATUS_RESET = 16'h0000;
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;
   // Interrupt events: acc A sat, acc B sat, acc A ovf, acc B ovf
   localparam int IRQ_EVENTS = 4;

   // Datapath result bundle
   typedef struct packed {
      logic       valid;      // Result flags below are meaningful
      logic       byte_op;    // Byte-sized operation
      logic [8:0] carry_vec;  // Carry out of each low-order bit position
      logic       negative;
      logic       overflow;
      logic       zero;
   } alu_result_t;

   // Accumulator condition bundle
   typedef struct packed {
      logic a_ovf;
      logic b_ovf;
      logic a_sat;
      logic b_sat;
   } acc_cond_t;
endpackage

//--- verilog/status_axil_slave.sv
// AXI4-Lite slave front end: one write and one read at a time.
// Assumes master holds valid until taken.
`timescale 1ns/1ps
`default_nettype none
module status_axil_slave (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   output logic             wr_stb,
   output logic [7:0]       wr_addr,
   output logic [31:0]      wr_data,
   output logic [3:0]       wr_strb,
   input  wire logic        wr_err,
   output logic             rd_stb,
   output logic [7:0]       rd_addr,
   input  wire logic [31:0] rd_data,
   input  wire logic        rd_err
);
   import status_flags_pkg::*;

   logic        aw_held_r, aw_held_nxt;
   logic        w_held_r, w_held_nxt;
   logic [7:0]  aw_addr_r, aw_addr_nxt;
   logic [31:0] w_data_r, w_data_nxt;
   logic [3:0]  w_strb_r, w_strb_nxt;
   logic        bvalid_r, bvalid_nxt;
   logic [1:0]  bresp_r, bresp_nxt;
   logic        rvalid_r, rvalid_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [1:0]  rresp_r, rresp_nxt;

   // -----------------------------------------------
   // Handshakes
   // -----------------------------------------------
   // AW and W held apart, either order
   assign awready = !aw_held_r && !bvalid_r;
   assign wready  = !w_held_r && !bvalid_r;
   assign arready = !rvalid_r;
   assign wr_stb  = aw_held_r && w_held_r && !bvalid_r;
   assign wr_addr = aw_addr_r;
   assign wr_data = w_data_r;
   assign wr_strb = w_strb_r;
   assign rd_stb  = arvalid && arready;
   assign rd_addr = araddr;
   assign bvalid  = bvalid_r;
   assign bresp   = bresp_r;
   assign rvalid  = rvalid_r;
   assign rdata   = rdata_r;
   assign rresp   = rresp_r;

   // Next state
   always_comb begin
      aw_held_nxt = aw_held_r;
      w_held_nxt  = w_held_r;
      aw_addr_nxt = aw_addr_r;
      w_data_nxt  = w_data_r;
      w_strb_nxt  = w_strb_r;
      bvalid_nxt  = bvalid_r;
      bresp_nxt   = bresp_r;
      rvalid_nxt  = rvalid_r;
      rdata_nxt   = rdata_r;
      rresp_nxt   = rresp_r;
      if (awvalid && awready) begin
         aw_held_nxt = 1'b1;
         aw_addr_nxt = awaddr;
      end
      if (wvalid && wready) begin
         w_held_nxt = 1'b1;
         w_data_nxt = wdata;
         w_strb_nxt = wstrb;
      end
      if (wr_stb) begin
         aw_held_nxt = 1'b0;
         w_held_nxt  = 1'b0;
         bvalid_nxt  = 1'b1;
         bresp_nxt   = wr_err ? RESP_SLVERR : RESP_OKAY;
      end else if (bvalid_r && bready) begin
         bvalid_nxt = 1'b0;
      end
      if (rd_stb) begin
         rvalid_nxt = 1'b1;
         rdata_nxt  = rd_data;
         rresp_nxt  = rd_err ? RESP_SLVERR : RESP_OKAY;
      end else if (rvalid_r && rready) begin
         rvalid_nxt = 1'b0;
      end
   end

   // Registers only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r <= 1'b0;
         w_held_r  <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r  <= 32'h0000_0000;
         w_strb_r  <= 4'h0;
         bvalid_r  <= 1'b0;
         bresp_r   <= RESP_OKAY;
         rvalid_r  <= 1'b0;
         rdata_r   <= 32'h0000_0000;
         rresp_r   <= RESP_OKAY;
      end else begin
         aw_held_r <= aw_held_nxt;
         w_held_r  <= w_held_nxt;
         aw_addr_r <= aw_addr_nxt;
         w_data_r  <= w_data_nxt;
         w_strb_r  <= w_strb_nxt;
         bvalid_r  <= bvalid_nxt;
         bresp_r   <= bresp_nxt;
         rvalid_r  <= rvalid_nxt;
         rdata_r   <= rdata_nxt;
         rresp_r   <= rresp_nxt;
      end
   end
endmodule
`default_nettype wire

//--- verilog/cpu_status_flags_register.sv
// Processor status flags register with AXI4-Lite access and event interrupt.
// Assumes datapath inputs synchronous to aclk.
//
// Operation
// - Acc A overflow flag at bit 15
// - Acc B overflow flag at bit 14
// - Acc A sticky saturation at bit 13
// - Acc B sticky saturation at bit 12
// - Bit 11 is OR of overflows
// - Bit 10 is OR of saturations
// - Software write or bit-10 clear changes saturations
// - Loop-active bit 9 follows hardware loop
// - Half carry from carry out of bit 3 (byte op) or bit 7 (word op)
// - Priority bits plus control bit 3 form level
// - Top priority bit blocks user interrupts
// - Nesting disable makes priority bits read-only
`timescale 1ns/1ps
`default_nettype none
module cpu_status_flags_register (
   input  wire logic                         aclk,
   input  wire logic                         aresetn,
   input  wire logic [7:0]                   awaddr,
   input  wire logic                         awvalid,
   output logic                              awready,
   input  wire logic [31:0]                  wdata,
   input  wire logic [3:0]                   wstrb,
   input  wire logic                         wvalid,
   output logic                              wready,
   output logic [1:0]                        bresp,
   output logic                              bvalid,
   input  wire logic                         bready,
   input  wire logic [7:0]                   araddr,
   input  wire logic                         arvalid,
   output logic                              arready,
   output logic [31:0]                       rdata,
   output logic [1:0]                        rresp,
   output logic                              rvalid,
   input  wire logic                         rready,
   input  wire status_flags_pkg::acc_cond_t   acc_cond,
   input  wire status_flags_pkg::alu_result_t alu_result,
   input  wire logic                         loop_running,
   input  wire logic                         repeat_running,
   output logic [15:0]                       cpu_status_flags,
   output logic [3:0]                        cpu_priority_level,
   output logic                              user_irq_blocked,
   output logic                              irq
);
   import status_flags_pkg::*;

   logic [15:0]           flags_r, flags_nxt;
   logic [15:0]           ctrl_r, ctrl_nxt;
   logic [IRQ_EVENTS-1:0] ev_stat_r, ev_stat_nxt;
   logic [IRQ_EVENTS-1:0] ev_mask_r, ev_mask_nxt;
   logic [IRQ_EVENTS-1:0] ev_now;
   logic                  wr_stb, rd_stb, wr_err, rd_err;
   logic [7:0]            wr_addr, rd_addr;
   logic [31:0]           wr_data, rd_data;
   logic [3:0]            wr_strb;
   logic [15:0]           wmask;
   logic                  wr_status, wr_ctrl, wr_mask;
   logic                  half_c;

   // -----------------------------------------------
   // Bus front end
   // -----------------------------------------------
   status_axil_slave u_bus (
      .aclk    (aclk),
      .aresetn (aresetn),
      .awaddr  (awaddr),
      .awvalid (awvalid),
      .awready (awready),
      .wdata   (wdata),
      .wstrb   (wstrb),
      .wvalid  (wvalid),
      .wready  (wready),
      .bresp   (bresp),
      .bvalid  (bvalid),
      .bready  (bready),
      .araddr  (araddr),
      .arvalid (arvalid),
      .arready (arready),
      .rdata   (rdata),
      .rresp   (rresp),
      .rvalid  (rvalid),
      .rready  (rready),
      .wr_stb  (wr_stb),
      .wr_addr (wr_addr),
      .wr_data (wr_data),
      .wr_strb (wr_strb),
      .wr_err  (wr_err),
      .rd_stb  (rd_stb),
      .rd_addr (rd_addr),
      .rd_data (rd_data),
      .rd_err  (rd_err)
   );

   // Shared decode
   function automatic logic addr_known(input logic [7:0] a);
      addr_known = (a == STATUS_OFFSET) || (a == CONTROL_OFFSET) ||
                   (a == PRIORITY_OFFSET) || (a == IRQ_STAT_OFFSET) ||
                   (a == IRQ_MASK_OFFSET);
   endfunction

   // Lane mask
   assign wmask     = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};
   assign wr_err    = !addr_known(wr_addr);
   assign rd_err    = !addr_known(rd_addr);
   assign wr_status = wr_stb && (wr_addr == STATUS_OFFSET);
   assign wr_ctrl   = wr_stb && (wr_addr == CONTROL_OFFSET);
   assign wr_mask   = wr_stb && (wr_addr == IRQ_MASK_OFFSET);

   // Half carry tap
   assign half_c = alu_result.byte_op ? alu_result.carry_vec[3]
                                      : alu_result.carry_vec[7];

   // -----------------------------------------------
   // Status flag next value
   // -----------------------------------------------
   // Hardware sets last, so set beats clear
   always_comb begin
      flags_nxt = flags_r;
      if (wr_status) begin
         // Direct sticky writes
         flags_nxt[BIT_ACC_A_SAT] = wmask[BIT_ACC_A_SAT] ?
                                    wr_data[BIT_ACC_A_SAT] : flags_r[BIT_ACC_A_SAT];
         flags_nxt[BIT_ACC_B_SAT] = wmask[BIT_ACC_B_SAT] ?
                                    wr_data[BIT_ACC_B_SAT] : flags_r[BIT_ACC_B_SAT];
         // Summary write 0 clears both
         if (wmask[BIT_ANY_SAT] && !wr_data[BIT_ANY_SAT]) begin
            flags_nxt[BIT_ACC_A_SAT] = 1'b0;
            flags_nxt[BIT_ACC_B_SAT] = 1'b0;
         end
         // Writable result flags
         if (wmask[BIT_HALF_CARRY]) begin
            flags_nxt[BIT_HALF_CARRY] = wr_data[BIT_HALF_CARRY];
         end
         if (wmask[0]) begin
            flags_nxt[BIT_NEGATIVE:BIT_CARRY] = wr_data[BIT_NEGATIVE:BIT_CARRY];
         end
         // Priority frozen by nesting disable
         if (wmask[BIT_PRIO_HI] && !ctrl_r[BIT_NEST_DIS]) begin
            flags_nxt[BIT_PRIO_HI:BIT_PRIO_LO] = wr_data[BIT_PRIO_HI:BIT_PRIO_LO];
         end
      end
      // Live overflow
      flags_nxt[BIT_ACC_A_OVF] = acc_cond.a_ovf;
      flags_nxt[BIT_ACC_B_OVF] = acc_cond.b_ovf;
      if (acc_cond.a_sat) begin
         flags_nxt[BIT_ACC_A_SAT] = 1'b1;
      end
      if (acc_cond.b_sat) begin
         flags_nxt[BIT_ACC_B_SAT] = 1'b1;
      end
      // Loop, repeat: hardware only
      flags_nxt[BIT_LOOP_ACTIVE] = loop_running;
      flags_nxt[BIT_REPEAT]      = repeat_running;
      if (alu_result.valid) begin
         flags_nxt[BIT_HALF_CARRY] = half_c;
         flags_nxt[BIT_NEGATIVE]   = alu_result.negative;
         flags_nxt[BIT_OVERFLOW]   = alu_result.overflow;
         flags_nxt[BIT_ZERO]       = alu_result.zero;
         flags_nxt[BIT_CARRY]      = alu_result.carry_vec[8];
      end
      // Derived summaries; set writes cannot stick
      flags_nxt[BIT_ANY_OVF] = flags_nxt[BIT_ACC_A_OVF] | flags_nxt[BIT_ACC_B_OVF];
      flags_nxt[BIT_ANY_SAT] = flags_nxt[BIT_ACC_A_SAT] | flags_nxt[BIT_ACC_B_SAT];
   end

   // -----------------------------------------------
   // Control, interrupt status and mask
   // -----------------------------------------------
   // Status read clears; new event survives
   always_comb begin
      ctrl_nxt    = ctrl_r;
      ev_mask_nxt = ev_mask_r;
      ev_stat_nxt = ev_stat_r;
      if (wr_ctrl) begin
         ctrl_nxt = (wr_data[15:0] & wmask) | (ctrl_r & ~wmask);
      end
      if (wr_mask && wr_strb[0]) begin
         ev_mask_nxt = wr_data[IRQ_EVENTS-1:0];
      end
      if (rd_stb && (rd_addr == IRQ_STAT_OFFSET)) begin
         ev_stat_nxt = '0;
      end
      ev_stat_nxt = ev_stat_nxt | ev_now;
   end

   // Overflow rising edges, and saturation while its sticky bit is clear, are events
   assign ev_now = {acc_cond.a_sat & ~flags_r[BIT_ACC_A_SAT],
                    acc_cond.b_sat & ~flags_r[BIT_ACC_B_SAT],
                    acc_cond.a_ovf & ~flags_r[BIT_ACC_A_OVF],
                    acc_cond.b_ovf & ~flags_r[BIT_ACC_B_OVF]};

   // Registers only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flags_r   <= STATUS_RESET;
         ctrl_r    <= 16'h0000;
         ev_stat_r <= '0;
         ev_mask_r <= '0;
      end else begin
         flags_r   <= flags_nxt;
         ctrl_r    <= ctrl_nxt;
         ev_stat_r <= ev_stat_nxt;
         ev_mask_r <= ev_mask_nxt;
      end
   end

   // -----------------------------------------------
   // Read mux and outputs
   // -----------------------------------------------
   // Read mux
   always_comb begin
      case (rd_addr)
         STATUS_OFFSET:   rd_data = {16'h0000, flags_r};
         CONTROL_OFFSET:  rd_data = {16'h0000, ctrl_r};
         PRIORITY_OFFSET: rd_data = {28'h0000000, cpu_priority_level};
         IRQ_STAT_OFFSET: rd_data = {28'h0000000, ev_stat_r};
         IRQ_MASK_OFFSET: rd_data = {28'h0000000, ev_mask_r};
         default:         rd_data = 32'h0000_0000;
      endcase
   end

   assign cpu_status_flags   = flags_r;
   assign cpu_priority_level = {ctrl_r[BIT_CORE_PRIO3],
                                flags_r[BIT_PRIO_HI:BIT_PRIO_LO]};
   assign user_irq_blocked   = ctrl_r[BIT_CORE_PRIO3];
   assign irq                = |(ev_stat_r & ev_mask_r);
endmodule
`default_nettype wire

//--- test/datapath_model.sv
// Behavioural datapath that drives the flag inputs of the status register.
// Assumes the bench calls its tasks; every change follows a rising aclk edge.
`timescale 1ns/1ps
`default_nettype none
module datapath_model
   import status_flags_pkg::*;
(
   input  wire logic                          aclk,
   output var  status_flags_pkg::acc_cond_t   acc_cond,
   output var  status_flags_pkg::alu_result_t alu_result,
   output var  logic                          loop_running,
   output var  logic                          repeat_running
);
   // Quiet at start
   initial begin
      acc_cond = '0;
      alu_result = '0;
      loop_running = 1'b0;
      repeat_running = 1'b0;
   end
   // Accumulator levels, one settle edge
   task automatic set_cond(input logic [3:0] c);
      @(posedge aclk);
      acc_cond <= acc_cond_t'(c);
      @(posedge aclk);
   endtask
   // One-cycle result, then scrambled
   task automatic pulse(input logic b, input logic [8:0] v, input logic n, input logic o,
                        input logic z);
      @(posedge aclk);
      alu_result <= {1'b1, b, v, n, o, z};
      @(posedge aclk);
      alu_result <= {1'b0, ~b, ~v, ~n, ~o, ~z};
   endtask
   // Hardware loop levels
   task automatic set_loop(input logic l, input logic r);
      @(posedge aclk);
      loop_running <= l;
      repeat_running <= r;
      @(posedge aclk);
   endtask
endmodule
`default_nettype wire

//--- test/status_flags_checker.sv
// Concurrent checks on the ports of the status flags register.
// Assumes aclk and sync active-low aresetn.
`timescale 1ns/1ps
`default_nettype none
module status_flags_checker
   import status_flags_pkg::*;
(
   input wire logic                          aclk,
   input wire logic                          aresetn,
   input wire logic [1:0]                    bresp,
   input wire logic                          bvalid,
   input wire logic                          bready,
   input wire logic [1:0]                    rresp,
   input wire logic                          rvalid,
   input wire logic                          rready,
   input wire status_flags_pkg::acc_cond_t   acc_cond,
   input wire status_flags_pkg::alu_result_t alu_result,
   input wire logic                          loop_running,
   input wire logic                          repeat_running,
   input wire logic [15:0]                   cpu_status_flags,
   input wire logic [3:0]                    cpu_priority_level,
   input wire logic                          user_irq_blocked
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ----------------------------------------
   // Accumulator flags
   // ----------------------------------------
   a_ovf_a: assert property (1'b1 |=> cpu_status_flags[15] == $past(acc_cond.a_ovf))
      else $error("acc A overflow flag wrong");
   a_ovf_b: assert property (1'b1 |=> cpu_status_flags[14] == $past(acc_cond.b_ovf))
      else $error("acc B overflow flag wrong");
   // Set wins over clear
   a_sat_a: assert property (acc_cond.a_sat |=> cpu_status_flags[13])
      else $error("acc A sat lost");
   a_sat_b: assert property (acc_cond.b_sat |=> cpu_status_flags[12])
      else $error("acc B sat lost");
   a_any_ovf: assert property (cpu_status_flags[11] == |cpu_status_flags[15:14])
      else $error("any ovf wrong");
   a_any_sat: assert property (cpu_status_flags[10] == |cpu_status_flags[13:12])
      else $error("any sat wrong");
   // ----------------------------------------
   // Loop, result and priority flags
   // ----------------------------------------
   a_loop_bit: assert property (1'b1 |=> cpu_status_flags[9] == $past(loop_running))
      else $error("loop active flag wrong");
   a_repeat_bit: assert property (##1 cpu_status_flags[4] == $past(repeat_running))
      else $error("repeat active flag wrong");
   a_hc_byte: assert property (alu_result.valid && alu_result.byte_op |=>
      cpu_status_flags[8] == $past(alu_result.carry_vec[3])) else $error("byte hc wrong");
   a_hc_word: assert property (alu_result.valid && !alu_result.byte_op |=>
      cpu_status_flags[8] == $past(alu_result.carry_vec[7])) else $error("word hc wrong");
   a_alu_flags: assert property (alu_result.valid |=> cpu_status_flags[3:0] ==
      {$past(alu_result.negative), $past(alu_result.overflow), $past(alu_result.zero),
       $past(alu_result.carry_vec[8])}) else $error("result flags wrong");
   a_prio_level: assert property ((cpu_priority_level == {user_irq_blocked,
      cpu_status_flags[7:5]})) else $error("priority level wrong");
   // Responses stand until taken
   a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("bresp dropped");
   a_rresp_hold: assert property (rvalid && !rready |=> rvalid && $stable(rresp))
      else $error("rresp dropped");
endmodule
bind cpu_status_flags_register status_flags_checker chk (
   .aclk(aclk), .aresetn(aresetn), .bresp(bresp), .bvalid(bvalid), .bready(bready),
   .rresp(rresp), .rvalid(rvalid), .rready(rready), .acc_cond(acc_cond),
   .alu_result(alu_result), .loop_running(loop_running), .repeat_running(repeat_running),
   .cpu_status_flags(cpu_status_flags), .cpu_priority_level(cpu_priority_level),
   .user_irq_blocked(user_irq_blocked)
);
`default_nettype wire

//--- test/cpu_status_flags_register_tb.sv
// Self-checking bench for the status flags register over AXI4-Lite.
// Assumes model and checker compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module cpu_status_flags_register_tb;
   import status_flags_pkg::*;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0]  wstrb = 4'hF, cpu_priority_level;
   logic        awready, wready, bvalid, arready, rvalid, user_irq_blocked, irq;
   logic [1:0]  bresp, rresp;
   logic [15:0] cpu_status_flags;
   acc_cond_t   acc_cond;
   alu_result_t alu_result;
   logic        loop_running, repeat_running;
   int          n_fail = 0;
   int          num_checks = 0;
   // Free-running 50 MHz clock
   always #10 aclk = ~aclk;
   cpu_status_flags_register dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .acc_cond(acc_cond), .alu_result(alu_result),
      .loop_running(loop_running), .repeat_running(repeat_running),
      .cpu_status_flags(cpu_status_flags), .cpu_priority_level(cpu_priority_level),
      .user_irq_blocked(user_irq_blocked), .irq(irq));
   datapath_model dp (.aclk(aclk), .acc_cond(acc_cond), .alu_result(alu_result),
      .loop_running(loop_running), .repeat_running(repeat_running));
   // ----------------------------------------
   // Compare and bus tasks
   // ----------------------------------------
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Handshakes read at negedge
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw, w, b;
      int   t;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      t = 0;
      do begin
         @(negedge aclk);
         aw = awvalid && awready;
         w = wvalid && wready;
         b = bvalid;
         r = bresp;
         @(posedge aclk);
         if (aw) awvalid <= 1'b0;
         if (w) wvalid <= 1'b0;
         t++;
      end while (!b && t < 64);
      bready <= 1'b0;
      chk("write answer", 32'h1, 32'(b));
   endtask
   task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ar, h;
      int   t;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      t = 0;
      do begin
         @(negedge aclk);
         ar = arvalid && arready;
         h = rvalid;
         d = rdata;
         r = rresp;
         @(posedge aclk);
         if (ar) arvalid <= 1'b0;
         t++;
      end while (!h && t < 64);
      rready <= 1'b0;
      chk("read answer", 32'h1, 32'(h));
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      axi_write(a, d, r);
      chk("bresp", 32'(RESP_OKAY), 32'(r));
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
      logic [31:0] d;
      logic [1:0]  r;
      axi_read(a, d, r);
      chk("rresp", 32'(RESP_OKAY), 32'(r));
      chk(what, exp, d);
   endtask
   // Irq read settled
   task automatic irq_chk(input logic exp);
      @(negedge aclk);
      chk("irq", 32'(exp), 32'(irq));
      @(posedge aclk);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_overflow();
      rd_chk(STATUS_OFFSET, 32'h0, "status after reset");
      dp.set_cond(4'h8);
      rd_chk(STATUS_OFFSET, 32'h8800, "acc A overflow");
      dp.set_cond(4'h4);
      rd_chk(STATUS_OFFSET, 32'h4800, "acc B overflow");
      dp.set_cond(4'h0);
      wr(STATUS_OFFSET, 32'hC800);
      rd_chk(STATUS_OFFSET, 32'h0, "overflow bits not writable");
      rd_chk(IRQ_STAT_OFFSET, 32'h3, "overflow events");
      rd_chk(IRQ_STAT_OFFSET, 32'h0, "event status read clears");
   endtask
   task automatic t_sticky();
      dp.set_cond(4'h2);
      dp.set_cond(4'h0);
      rd_chk(STATUS_OFFSET, 32'h2400, "acc A sticky");
      irq_chk(1'b0);
      wr(IRQ_MASK_OFFSET, 32'h8);
      rd_chk(IRQ_MASK_OFFSET, 32'h8, "mask readback");
      irq_chk(1'b1);
      rd_chk(IRQ_STAT_OFFSET, 32'h8, "saturation event");
      rd_chk(IRQ_STAT_OFFSET, 32'h0, "event cleared");
      irq_chk(1'b0);
      dp.set_cond(4'h1);
      dp.set_cond(4'h0);
      rd_chk(STATUS_OFFSET, 32'h3400, "acc B sticky");
      // Whole-word writes only: combined clear, then direct set and direct clear of the acc A sticky
      wr(STATUS_OFFSET, 32'h0000);
      rd_chk(STATUS_OFFSET, 32'h0, "combined clear drops both");
      wr(STATUS_OFFSET, 32'h2400);
      rd_chk(STATUS_OFFSET, 32'h2400, "direct sticky set");
      wr(STATUS_OFFSET, 32'h0400);
      rd_chk(STATUS_OFFSET, 32'h0, "direct sticky clear");
   endtask
   task automatic t_result();
      wr(STATUS_OFFSET, 32'h021F);
      rd_chk(STATUS_OFFSET, 32'h000F, "result flags written");
      wstrb <= 4'h2;
      wr(STATUS_OFFSET, 32'h0000);
      wstrb <= 4'hF;
      rd_chk(STATUS_OFFSET, 32'h000F, "high lane only");
      dp.pulse(1'b1, 9'h018, 1'b1, 1'b0, 1'b1);
      rd_chk(STATUS_OFFSET, 32'h010A, "byte half carry");
      dp.pulse(1'b0, 9'h018, 1'b0, 1'b1, 1'b0);
      rd_chk(STATUS_OFFSET, 32'h0004, "word no half carry");
      dp.pulse(1'b0, 9'h180, 1'b0, 1'b0, 1'b0);
      rd_chk(STATUS_OFFSET, 32'h0101, "word half carry");
      dp.set_loop(1'b1, 1'b1);
      rd_chk(STATUS_OFFSET, 32'h0311, "loop running");
      dp.set_loop(1'b0, 1'b0);
      rd_chk(STATUS_OFFSET, 32'h0101, "loop ended");
   endtask
   task automatic t_priority();
      logic [31:0] d;
      logic [1:0]  r;
      wr(STATUS_OFFSET, 32'h00E0);
      rd_chk(PRIORITY_OFFSET, 32'h7, "level low bits");
      wr(CONTROL_OFFSET, 32'h0008);
      rd_chk(PRIORITY_OFFSET, 32'hF, "level top bit");
      chk("user irq blocked", 32'h1, 32'(user_irq_blocked));
      wr(CONTROL_OFFSET, 32'h8008);
      wr(STATUS_OFFSET, 32'h0020);
      rd_chk(STATUS_OFFSET, 32'h00E0, "priority locked");
      wr(CONTROL_OFFSET, 32'h0000);
      wr(STATUS_OFFSET, 32'h0020);
      rd_chk(STATUS_OFFSET, 32'h0020, "priority unlocked");
      axi_read(8'h20, d, r);
      chk("unmapped rresp", 32'(RESP_SLVERR), 32'(r));
      chk("unmapped rdata", 32'h0, d);
      axi_write(8'h20, 32'hFFFF, r);
      chk("unmapped bresp", 32'(RESP_SLVERR), 32'(r));
   endtask
   // ----------------------------------------
   // Sequence, watchdog and verdict
   // ----------------------------------------
   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_overflow();
      t_sticky();
      t_result();
      t_priority();
      close_out();
   end
   // Watchdog
   initial begin
      repeat (20000) @(posedge aclk);
      n_fail++;
      close_out();
   end
endmodule
`default_nettype wire
